/* File: logic/ufs_status.sv */
// fifo occupancy counters, status flags, level registers and interrupt
// assumes queue events and the busy level come from logic on ref_clk
//
// The implementer's own choice: strobed register access.
module ufs_status
  import ufs_pkg::*;
(
  input wire logic ref_clk, // peripheral clock, 250 MHz
  input wire logic nrst, // async reset, active low
  input wire ufs_bus_t bus, // register port request
  input wire ufs_qev_t tx_ev, // transmit queue push/pop/flush
  input wire ufs_qev_t rx_ev, // receive queue push/pop/flush
  input wire logic serial_active, // validated char in flight
  output logic [UFS_DW-1:0] rdata, // read data, cycle after rd
  output logic [4:0] status_flags, // live status word bits
  output logic irq // level interrupt
);
  // ==========================================
  // occupancy counters
  logic [15:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;

  function automatic logic [15:0] step(input logic [15:0] c, input ufs_qev_t e);
    logic [15:0] r;
    r = c;
    if (e.flush) begin
      r = 16'h0000; // see RULE11
    end else if (e.push && !e.pop && c < UFS_DEPTH) begin
      r = c + 16'h0001; // see RULE10
    end else if (e.pop && !e.push && c != 16'h0000) begin
      r = c - 16'h0001;
    end else if (e.push && e.pop && c == 16'h0000) begin
      r = 16'h0001;
    end
    return r;
  endfunction

  always_comb begin
    tx_cnt_next = step(tx_cnt_reg, tx_ev); // see RULE8
    rx_cnt_next = step(rx_cnt_reg, rx_ev); // see RULE9
  end

  // ==========================================
  // queue flags from the counter next values, so flags and levels move together
  logic [4:0] flags_next;
  logic busy_reg;
  always_comb begin
    flags_next = '0;
    flags_next[UFS_BIT_RFF] = (rx_cnt_next == UFS_DEPTH); // see RULE1 RULE12
    flags_next[UFS_BIT_RFNE] = (rx_cnt_next != 16'h0000); // see RULE2
    flags_next[UFS_BIT_TFE] = (tx_cnt_next == 16'h0000); // see RULE3
    flags_next[UFS_BIT_TFNF] = (tx_cnt_next != UFS_DEPTH); // see RULE4
    // busy comes from the serial engine only after mid-bit validation
    flags_next[UFS_BIT_BUSY] = busy_reg; // see RULE5 RULE6
  end

  // ==========================================
  // busy input is same-clock; single clock so no extra crossing delay
  logic busy_next;
  always_comb begin
    busy_next = serial_active; // see RULE7
  end

  // ==========================================
  // interrupt status and mask
  logic [3:0] ist_reg, ist_next, msk_reg, msk_next, ev;
  logic irq_next;
  always_comb begin
    ev = {busy_reg & ~busy_next, flags_next[UFS_BIT_TFE] & ~status_flags[UFS_BIT_TFE],
          flags_next[UFS_BIT_RFNE] & ~status_flags[UFS_BIT_RFNE],
          flags_next[UFS_BIT_RFF] & ~status_flags[UFS_BIT_RFF]};
    ist_next = ist_reg;
    msk_next = msk_reg;
    if (bus.wr && bus.addr == UFS_IRQ_STAT_ADDR) begin
      ist_next = ist_reg & ~bus.wdata[3:0];
    end else if (bus.wr && bus.addr == UFS_IRQ_MASK_ADDR) begin
      msk_next = bus.wdata[3:0];
    end
    ist_next = ist_next | ev; // set wins over clear
    irq_next = |(ist_next & msk_next);
  end

  // ==========================================
  // read decode; unmapped reads return zero
  logic [UFS_DW-1:0] rdata_next;
  always_comb begin
    rdata_next = '0;
    if (bus.rd) begin
      if (bus.addr == UFS_STATUS_ADDR) begin
        rdata_next = {27'h0, status_flags};
      end else if (bus.addr == UFS_TXLVL_ADDR) begin
        rdata_next = {16'h0000, tx_cnt_reg};
      end else if (bus.addr == UFS_RXLVL_ADDR) begin
        rdata_next = {16'h0000, rx_cnt_reg};
      end else if (bus.addr == UFS_IRQ_STAT_ADDR) begin
        rdata_next = {28'h0000000, ist_reg};
      end else if (bus.addr == UFS_IRQ_MASK_ADDR) begin
        rdata_next = {28'h0000000, msk_reg};
      end
    end
  end

  // ==========================================
  // state registers, one process per group
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_cnt_reg <= 16'h0000;
      rx_cnt_reg <= 16'h0000;
    end else begin
      tx_cnt_reg <= tx_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_flags <= UFS_STATUS_RST;
    end else begin
      status_flags <= flags_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ist_reg <= 4'h0;
      msk_reg <= UFS_MASK_RST;
      irq <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      msk_reg <= msk_next;
      irq <= irq_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_next;
    end
  end

  // ==========================================
  // assertions
  rx_full_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    status_flags[UFS_BIT_RFF] == (rx_cnt_reg == UFS_DEPTH)) // see RULE1
    else $error("rx full flag disagrees with level");
  rx_nonempty_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    status_flags[UFS_BIT_RFNE] == (rx_cnt_reg != 16'h0000)) // see RULE2
    else $error("rx not empty flag disagrees with level");
  tx_empty_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    status_flags[UFS_BIT_TFE] == (tx_cnt_reg == 16'h0000)) // see RULE3
    else $error("tx empty flag disagrees with level");
  tx_space_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    status_flags[UFS_BIT_TFNF] == (tx_cnt_reg != UFS_DEPTH)) // see RULE4
    else $error("tx space flag disagrees with level");
  busy_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    serial_active |=> ##1 status_flags[UFS_BIT_BUSY]) // see RULE5
    else $error("busy flag did not follow activity");
  tx_level_step_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tx_ev.push && !tx_ev.pop && !tx_ev.flush && tx_cnt_reg < UFS_DEPTH)
    |=> tx_cnt_reg == $past(tx_cnt_reg) + 16'h0001) // see RULE8
    else $error("tx level did not count a push");
  rx_level_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_cnt_reg <= UFS_DEPTH && tx_cnt_reg <= UFS_DEPTH) // see RULE9 RULE10
    else $error("level exceeds depth");
  flush_clears_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_ev.flush |=> rx_cnt_reg == 16'h0000 && !status_flags[UFS_BIT_RFNE]) // see RULE11
    else $error("rx flush did not empty the queue");
  read_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (bus.rd && bus.addr == UFS_TXLVL_ADDR) |=> rdata[15:0] == $past(tx_cnt_reg)) // see RULE12
    else $error("tx level read wrong");
  rx_level_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE9
    (bus.rd && bus.addr == UFS_RXLVL_ADDR) |=> rdata == {16'h0000, $past(rx_cnt_reg)})
    else $error("rx level read wrong");
  status_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE12
    (bus.rd && bus.addr == UFS_STATUS_ADDR) |=> rdata == {27'h0, $past(status_flags)})
    else $error("status read wrong");
  irq_stat_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (bus.rd && bus.addr == UFS_IRQ_STAT_ADDR) |=> rdata == {28'h0, $past(ist_reg)})
    else $error("irq status read wrong");
  mask_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (bus.rd && bus.addr == UFS_IRQ_MASK_ADDR) |=> rdata == {28'h0, $past(msk_reg)})
    else $error("irq mask read wrong");
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !bus.rd |=> rdata == '0)
    else $error("read data not zero outside a read");

  // ==========================================
  // level counter steps
  rx_level_push_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE9
    (rx_ev.push && !rx_ev.pop && !rx_ev.flush && rx_cnt_reg < UFS_DEPTH)
    |=> rx_cnt_reg == $past(rx_cnt_reg) + 16'h0001) else $error("rx level missed a push");
  tx_level_pop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE8
    (tx_ev.pop && !tx_ev.push && !tx_ev.flush && tx_cnt_reg != 16'h0000)
    |=> tx_cnt_reg == $past(tx_cnt_reg) - 16'h0001) else $error("tx level missed a pop");
  rx_level_pop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE9
    (rx_ev.pop && !rx_ev.push && !rx_ev.flush && rx_cnt_reg != 16'h0000)
    |=> rx_cnt_reg == $past(rx_cnt_reg) - 16'h0001) else $error("rx level missed a pop");
  tx_level_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE8
    tx_ev == '0 |=> tx_cnt_reg == $past(tx_cnt_reg))
    else $error("tx level moved without an event");
  rx_level_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE9
    rx_ev == '0 |=> rx_cnt_reg == $past(rx_cnt_reg))
    else $error("rx level moved without an event");
  tx_pushpop_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE8
    (tx_ev.push && tx_ev.pop && !tx_ev.flush && tx_cnt_reg != 16'h0000)
    |=> tx_cnt_reg == $past(tx_cnt_reg)) else $error("tx push and pop changed level");
  rx_pushpop_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE9
    (rx_ev.push && rx_ev.pop && !rx_ev.flush && rx_cnt_reg != 16'h0000)
    |=> rx_cnt_reg == $past(rx_cnt_reg)) else $error("rx push and pop changed level");
  tx_pushpop_empty_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE8
    (tx_ev.push && tx_ev.pop && !tx_ev.flush && tx_cnt_reg == 16'h0000)
    |=> tx_cnt_reg == 16'h0001) else $error("tx push and pop on empty wrong");
  rx_pushpop_empty_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE9
    (rx_ev.push && rx_ev.pop && !rx_ev.flush && rx_cnt_reg == 16'h0000)
    |=> rx_cnt_reg == 16'h0001) else $error("rx push and pop on empty wrong");
  tx_pop_empty_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE8
    (tx_ev.pop && !tx_ev.push && !tx_ev.flush && tx_cnt_reg == 16'h0000)
    |=> tx_cnt_reg == 16'h0000) else $error("tx pop on empty moved level");
  rx_pop_empty_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE9
    (rx_ev.pop && !rx_ev.push && !rx_ev.flush && rx_cnt_reg == 16'h0000)
    |=> rx_cnt_reg == 16'h0000) else $error("rx pop on empty moved level");
  tx_full_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE10
    (tx_ev.push && !tx_ev.pop && !tx_ev.flush && tx_cnt_reg == UFS_DEPTH)
    |=> tx_cnt_reg == UFS_DEPTH) else $error("tx push at depth not ignored");
  rx_full_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE10
    (rx_ev.push && !rx_ev.pop && !rx_ev.flush && rx_cnt_reg == UFS_DEPTH)
    |=> rx_cnt_reg == UFS_DEPTH) else $error("rx push at depth not ignored");
  tx_flush_wins_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE11
    tx_ev.flush |=> tx_cnt_reg == 16'h0000 && status_flags[UFS_BIT_TFE])
    else $error("tx flush did not empty the queue");
  ro_write_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE8 RULE9
    (bus.wr && tx_ev == '0 && rx_ev == '0)
    |=> tx_cnt_reg == $past(tx_cnt_reg) && rx_cnt_reg == $past(rx_cnt_reg))
    else $error("write changed a read-only level");

  // ==========================================
  // flag pairs and edges
  rx_flag_pair_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE12
    !(status_flags[UFS_BIT_RFF] && !status_flags[UFS_BIT_RFNE]))
    else $error("rx full while empty");
  tx_flag_pair_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE12
    !(status_flags[UFS_BIT_TFE] && !status_flags[UFS_BIT_TFNF]))
    else $error("tx empty while full");
  rx_fill_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE1
    (rx_ev.push && !rx_ev.pop && !rx_ev.flush && rx_cnt_reg == UFS_DEPTH - 16'h0001)
    |=> status_flags[UFS_BIT_RFF]) else $error("rx full flag did not rise");
  rx_unfull_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE1
    (rx_ev.pop && !rx_ev.push && !rx_ev.flush && rx_cnt_reg == UFS_DEPTH)
    |=> !status_flags[UFS_BIT_RFF]) else $error("rx full flag did not clear");
  rx_drain_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE2
    (rx_ev.pop && !rx_ev.push && !rx_ev.flush && rx_cnt_reg == 16'h0001)
    |=> !status_flags[UFS_BIT_RFNE]) else $error("rx not empty flag did not clear");
  tx_push_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE3
    (tx_ev.push && !tx_ev.pop && !tx_ev.flush && tx_cnt_reg == 16'h0000)
    |=> !status_flags[UFS_BIT_TFE]) else $error("tx empty flag did not clear");
  tx_fill_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE4
    (tx_ev.push && !tx_ev.pop && !tx_ev.flush && tx_cnt_reg == UFS_DEPTH - 16'h0001)
    |=> !status_flags[UFS_BIT_TFNF]) else $error("tx space flag did not clear");
  busy_drop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE5
    !serial_active |=> ##1 !status_flags[UFS_BIT_BUSY])
    else $error("busy flag did not drop");

  // ==========================================
  // interrupt status, mask and line
  irq_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    irq == |(ist_reg & msk_reg))
    else $error("irq line disagrees with status and mask");
  mask_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (bus.wr && bus.addr == UFS_IRQ_MASK_ADDR) |=> msk_reg == $past(bus.wdata[3:0]))
    else $error("mask write did not land");
  set_wins_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (bus.wr && bus.addr == UFS_IRQ_STAT_ADDR && bus.wdata[1] && rx_ev.push && !rx_ev.flush
    && rx_cnt_reg == 16'h0000) |=> ist_reg[1]) else $error("clear beat a new event");
  ist_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ist_reg[1] && !(bus.wr && bus.addr == UFS_IRQ_STAT_ADDR && bus.wdata[1]))
    |=> ist_reg[1]) else $error("irq status bit lost without a clear");
  ist_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ist_reg[1] && bus.wr && bus.addr == UFS_IRQ_STAT_ADDR && bus.wdata[1] && rx_ev == '0)
    |=> !ist_reg[1]) else $error("irq status bit not cleared");
  rx_data_irq_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE2
    (rx_cnt_reg == 16'h0000 && rx_ev.push && !rx_ev.flush) |=> ist_reg[1])
    else $error("rx data event missed");
  rx_full_irq_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE1
    (rx_ev.push && !rx_ev.pop && !rx_ev.flush && rx_cnt_reg == UFS_DEPTH - 16'h0001)
    |=> ist_reg[0]) else $error("rx full event missed");
  tx_empty_irq_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE3
    (tx_ev.pop && !tx_ev.push && !tx_ev.flush && tx_cnt_reg == 16'h0001)
    |=> ist_reg[2]) else $error("tx empty event missed");
  busy_fell_irq_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE5
    (busy_reg && !serial_active) |=> ist_reg[3])
    else $error("busy fell event missed");

  // ==========================================
  // main scenarios
  rx_fills_c: cover property (@(posedge ref_clk) disable iff (!nrst) status_flags[UFS_BIT_RFF]);
  tx_full_c: cover property (@(posedge ref_clk) disable iff (!nrst) !status_flags[UFS_BIT_TFNF]);
  irq_c: cover property (@(posedge ref_clk) disable iff (!nrst) irq);
  busy_c: cover property (@(posedge ref_clk) disable iff (!nrst) status_flags[UFS_BIT_BUSY]);
  rx_flush_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    rx_ev.flush && rx_cnt_reg != 16'h0000);
endmodule

/* File: common/ufs_pkg.sv */
// constants, field layout and carrier types for the fifo status and level block
// assumes one peripheral clock; fifo push/pop/flush events come from same-clock logic
// Summary of operation
// RULE1: status bit 4 is high exactly while the receive queue holds its full depth.
// RULE2: status bit 3 is high whenever the receive queue holds one or more entries.
// RULE3: status bit 2 is high while the transmit queue is empty and resets to one.
// RULE4: status bit 1 is high while the transmit queue has room and resets to one.
// RULE5: status bit 0 shows a character being sent or received and resets to zero.
// RULE6: the activity bit may stay low until a start bit is validated at mid-bit.
// RULE7: with a separate serial clock the activity bit rises a few slow cycles late.
// RULE8: a read-only 16-bit transmit level counts entries and resets to zero.
// RULE9: a read-only 16-bit receive level counts entries and resets to zero.
// RULE10: each queue is sixteen deep; that depth sets full and bounds the levels.
// RULE11: a queue flush clears its count at once so its empty flags assert.
// RULE12: all four flags come from the same counters that feed the level registers.
package ufs_pkg;
  localparam int unsigned UFS_AW = 32;
  localparam int unsigned UFS_DW = 32;
  localparam logic [31:0] UFS_STATUS_ADDR = 32'h5000117c;
  localparam logic [31:0] UFS_TXLVL_ADDR = 32'h50001180;
  localparam logic [31:0] UFS_RXLVL_ADDR = 32'h50001184;
  localparam logic [31:0] UFS_IRQ_STAT_ADDR = 32'h50001194;
  localparam logic [31:0] UFS_IRQ_MASK_ADDR = 32'h50001198;
  localparam logic [15:0] UFS_DEPTH = 16'h0010;
  localparam int unsigned UFS_BIT_RFF = 4;
  localparam int unsigned UFS_BIT_RFNE = 3;
  localparam int unsigned UFS_BIT_TFE = 2;
  localparam int unsigned UFS_BIT_TFNF = 1;
  localparam int unsigned UFS_BIT_BUSY = 0;
  localparam logic [4:0] UFS_STATUS_RST = 5'h06;
  localparam int unsigned UFS_NIRQ = 4;
  // irq bits: 0 rx full, 1 rx data, 2 tx empty, 3 busy fell
  localparam logic [3:0] UFS_MASK_RST = 4'h0;

  typedef struct packed {
    logic push;
    logic pop;
    logic flush;
  } ufs_qev_t;

  typedef struct packed {
    logic [UFS_AW-1:0] addr;
    logic [UFS_DW-1:0] wdata;
    logic wr;
    logic rd;
  } ufs_bus_t;
endpackage

/* File: verif/ufs_remote.sv */
// stand-in for the remote serial device: raises the in-flight level per character
// assumes ref_clk domain; a start request while a character runs is dropped
module ufs_remote (
  input wire logic ref_clk, // peripheral clock
  input wire logic nrst, // async reset, active low
  input wire logic go, // start one character
  output logic serial_active // validated character in flight
);
  timeunit 1ns;
  timeprecision 100ps;
  // ============================================================
  // character timer
  logic [3:0] cnt_reg, cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end else if (go) begin
      cnt_next = 4'ha;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cnt_reg <= 4'h0;
    else cnt_reg <= cnt_next;
  end
  // only a validated start counts, so the level rises a cycle after go
  assign serial_active = cnt_reg != 4'h0;
endmodule

/* File: verif/ufs_status_test.sv */
// self-checking bench for ufs_status: random queue traffic, level reads, interrupt
// assumes ufs_remote supplies the in-flight level
module ufs_status_test;
  import ufs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ============================================================
  // stimulus and models
  logic ref_clk = 1'b0, nrst = 1'b0, go = 1'b0, serial_active, irq;
  ufs_bus_t bus = '0;
  ufs_qev_t tx_ev = '0, rx_ev = '0;
  logic [UFS_DW-1:0] rdata;
  logic [4:0] status_flags;
  logic [15:0] tx_n = 16'h0, rx_n = 16'h0;
  logic [1:0] sa_q = 2'b0;
  int n_errors = 0, num_checks = 0, seed = 32'hf7006018;
  ufs_status i_ufs_status (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .tx_ev(tx_ev),
    .rx_ev(rx_ev), .serial_active(serial_active), .rdata(rdata),
    .status_flags(status_flags), .irq(irq));
  ufs_remote i_ufs_remote (.ref_clk(ref_clk), .nrst(nrst), .go(go),
    .serial_active(serial_active));
  function automatic logic [15:0] nxt(logic [15:0] c, ufs_qev_t e);
    if (e.flush) return 16'h0;
    if (e.push && e.pop) return (c == 16'h0) ? 16'h1 : c;
    if (e.push) return (c < UFS_DEPTH) ? c + 16'h1 : c;
    if (e.pop) return (c != 16'h0) ? c - 16'h1 : c;
    return c;
  endfunction
  function automatic logic [4:0] flags(logic [15:0] t, logic [15:0] r, logic b);
    return {r == UFS_DEPTH, r != 16'h0, t == 16'h0, t != UFS_DEPTH, b};
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ============================================================
  // bus and traffic tasks
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic drive(ufs_qev_t t, ufs_qev_t r, logic g);
    @(posedge ref_clk);
    tx_ev <= t;
    rx_ev <= r;
    go <= g;
    #1 chk(status_flags, flags(tx_n, rx_n, sa_q[1]));
    sa_q = {sa_q[0], serial_active};
    tx_n = nxt(tx_n, t);
    rx_n = nxt(rx_n, r);
  endtask
  task automatic step(int pp);
    ufs_qev_t t, r;
    t = {($random(seed) & 255) < pp, ($random(seed) & 255) > pp, ($random(seed) & 127) == 0};
    r = {($random(seed) & 255) < pp, ($random(seed) & 255) > pp, ($random(seed) & 127) == 0};
    drive(t, r, ($random(seed) & 7) == 0);
  endtask
  // idle tail lets the remote go quiet so the busy history stays valid
  task automatic idle(int n);
    repeat (n) drive('0, '0, 1'b0);
  endtask
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #100000 n_errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    #1 chk(status_flags, UFS_STATUS_RST);
    rd(UFS_TXLVL_ADDR, 32'h0);
    rd(UFS_RXLVL_ADDR, 32'h0);
    $display("reset test done");
    for (int ph = 0; ph < 4; ph++) begin
      repeat (150) step(ph[0] ? 60 : 190);
      idle(12);
      rd(UFS_TXLVL_ADDR, {16'h0, tx_n});
      wr(UFS_RXLVL_ADDR, 32'hffff);
      rd(UFS_RXLVL_ADDR, {16'h0, rx_n});
      rd(32'h500011a0, 32'h0);
      $display("traffic phase %0d done", ph);
    end
    drive(3'b001, 3'b001, 1'b0);
    idle(12);
    wr(UFS_IRQ_STAT_ADDR, 32'hf);
    drive('0, 3'b100, 1'b0);
    idle(3);
    chk(irq, 32'h0);
    wr(UFS_IRQ_MASK_ADDR, 32'h2);
    idle(3);
    chk(irq, 32'h1);
    rd(UFS_IRQ_STAT_ADDR, 32'h2);
    wr(UFS_IRQ_STAT_ADDR, 32'h2);
    idle(3);
    chk(irq, 32'h0);
    $display("interrupt test done");
    give_verdict();
  end
endmodule
